// >>> hdl/chip_reset_sequencer.sv
`timescale 1ns/1ps
`include "crs_consts.svh"

module chip_reset_sequencer
  import crs_pkg::*;
#(
  parameter int WAKE_COUNT = `CRS_WAKE_COUNT
) (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        extResetPinN,
  input  wire logic        watchdogTimerReset,
  input  wire logic        powerOnReset,
  input  wire logic        brownoutDetectorReset,
  input  wire logic        supplyUsable,
  input  wire logic        crystalOscSample,
  input  wire logic        flashInitDone,
  output logic             chipReset,
  output logic             internalResetN,
  output logic             regResetReq,
  output logic             flashInitStart,
  output logic             crystalStable,
  output logic [31:0]      fetchAddr,
  output logic [1:0]       clockSelect,
  output logic             pllEnable,
  output logic             pllConnect
);
  crs_state_t                 state_reg;
  crs_state_t                 state_next;
  logic [`CRS_CNT_W-1:0]      wakeCnt_reg;
  logic [`CRS_CNT_W-1:0]      wakeCnt_next;
  logic                       chipReset_reg;
  logic                       chipReset_next;
  logic                       intRstN_reg;
  logic                       intRstN_next;
  logic                       flashStart_reg;
  logic                       flashStart_next;
  logic                       xtalStable_reg;
  logic                       anySource;
  logic                       oscRunning;
  logic                       regResetReq_reg;
  logic                       regResetReq_next;
  logic [31:0]                fetchAddr_reg;
  logic [31:0]                fetchAddr_next;
  logic [1:0]                 clockSel_reg;
  logic [1:0]                 clockSel_next;
  logic                       pllEnable_reg;
  logic                       pllEnable_next;
  logic                       pllConnect_reg;
  logic                       pllConnect_next;

  localparam logic [`CRS_CNT_W-1:0] WAKE_LAST = `CRS_CNT_W'(WAKE_COUNT - 1);

  assign anySource = !extResetPinN || watchdogTimerReset || powerOnReset
                     || brownoutDetectorReset;

  crs_osc_monitor u_osc (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .restart   (anySource || !supplyUsable),
    .oscSample (crystalOscSample),
    .oscStable (oscRunning)
  );

  always_comb begin
    state_next      = state_reg;
    wakeCnt_next    = wakeCnt_reg;
    chipReset_next  = anySource;
    intRstN_next    = 1'b0;
    flashStart_next = 1'b0;
    fetchAddr_next  = `CRS_BOOT_ADDR;
    clockSel_next   = `CRS_CLKSEL_IRC;
    pllEnable_next  = `CRS_PLL_OFF;
    pllConnect_next = `CRS_PLL_OFF;
    // restart timer on any source or while supply is not usable
    if (anySource || !supplyUsable) begin
      state_next   = CRS_ST_HOLD;
      wakeCnt_next = '0;
    end else begin
      case (state_reg)
        CRS_ST_HOLD: begin
          state_next = CRS_ST_OSC;
        end
        CRS_ST_OSC: begin
          if (oscRunning) begin
            state_next = CRS_ST_COUNT;
          end
        end
        CRS_ST_COUNT: begin
          if (wakeCnt_reg == WAKE_LAST) begin
            state_next      = CRS_ST_FLASH;
            flashStart_next = 1'b1;
          end else begin
            wakeCnt_next = wakeCnt_reg + `CRS_CNT_W'(1);
          end
        end
        CRS_ST_FLASH: begin
          // a done level left from before a restart is not trusted during the start pulse
          if (flashInitDone && !flashStart_reg) begin
            state_next   = CRS_ST_RUN;
            intRstN_next = 1'b1;
          end
        end
        CRS_ST_RUN: begin
          intRstN_next = 1'b1;
        end
        default: begin
          state_next = CRS_ST_HOLD;
        end
      endcase
    end
    // registers stay in reset until internal reset is removed
    regResetReq_next = !intRstN_next;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg      <= CRS_ST_HOLD;
      wakeCnt_reg    <= '0;
      chipReset_reg  <= 1'b1;
      intRstN_reg    <= 1'b0;
      flashStart_reg <= 1'b0;
      xtalStable_reg <= 1'b0;
      regResetReq_reg <= 1'b1;
      fetchAddr_reg  <= `CRS_BOOT_ADDR;
      clockSel_reg   <= `CRS_CLKSEL_IRC;
      pllEnable_reg  <= `CRS_PLL_OFF;
      pllConnect_reg <= `CRS_PLL_OFF;
    end else begin
      state_reg      <= state_next;
      wakeCnt_reg    <= wakeCnt_next;
      chipReset_reg  <= chipReset_next;
      intRstN_reg    <= intRstN_next;
      flashStart_reg <= flashStart_next;
      xtalStable_reg <= oscRunning;
      regResetReq_reg <= regResetReq_next;
      fetchAddr_reg  <= fetchAddr_next;
      clockSel_reg   <= clockSel_next;
      pllEnable_reg  <= pllEnable_next;
      pllConnect_reg <= pllConnect_next;
    end
  end

  assign chipReset      = chipReset_reg;
  assign internalResetN = intRstN_reg;
  assign regResetReq    = regResetReq_reg;
  assign flashInitStart = flashStart_reg;
  assign crystalStable  = xtalStable_reg;
  assign fetchAddr      = fetchAddr_reg;
  assign clockSelect    = clockSel_reg;
  assign pllEnable      = pllEnable_reg;
  assign pllConnect     = pllConnect_reg;

  // assertions
  // source forces reset
  chip_reset_src_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    (!extResetPinN || watchdogTimerReset || powerOnReset || brownoutDetectorReset)
      |=> chipReset && !internalResetN)
    else $error("reset source did not assert chip reset");
  release_needs_flash_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(internalResetN) |-> $past(flashInitDone) && $past(state_reg == CRS_ST_FLASH))
    else $error("internal reset released without flash done");
  release_needs_osc_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(internalResetN) |-> crystalStable)
    else $error("internal reset released before oscillator stable");
  count_restart_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    anySource |=> wakeCnt_reg == '0 && state_reg == CRS_ST_HOLD)
    else $error("wake count not restarted by reset source");
  supply_gate_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    !supplyUsable |=> state_reg == CRS_ST_HOLD && !internalResetN)
    else $error("wake timer ran without usable supply");
  reg_reset_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    regResetReq != internalResetN && regResetReq == (state_reg != CRS_ST_RUN))
    else $error("register reset request disagrees with internal reset");
  xtal_flag_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    anySource |=> ##1 !crystalStable)
    else $error("crystal stable flag not cleared by reset");
  boot_vector_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(internalResetN) |-> fetchAddr == 32'h0000_0000)
    else $error("fetch address not zero at release");
  pll_off_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    !internalResetN |-> !pllEnable && !pllConnect && clockSelect == 2'h0)
    else $error("pll or clock select wrong during reset");
  chip_reset_clear_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    !anySource |=> !chipReset)
    else $error("chip reset held with no source active");
  run_no_chip_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    internalResetN |-> !chipReset)
    else $error("internal reset released while chip reset active");
  flash_start_pulse_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    flashInitStart |-> state_reg == CRS_ST_FLASH ##1 !flashInitStart)
    else $error("flash start not a single pulse in flash wait");
  count_full_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    flashInitStart |-> $past(wakeCnt_reg) == WAKE_LAST && crystalStable)
    else $error("flash start before full wake count");
endmodule // chip_reset_sequencer

// >>> hdl/crs_consts.svh
`ifndef CRS_CONSTS_SVH
`define CRS_CONSTS_SVH

// post-oscillator clock count before reset release
`define CRS_WAKE_COUNT      16'h0400
// wake counter width
`define CRS_CNT_W           16
// unused; supplyUsable enters the sequencer with no power-good filter
`define CRS_SYNC_W          2
// fetch address on reset release
`define CRS_BOOT_ADDR       32'h0000_0000
// clock select code for the internal rc oscillator
`define CRS_CLKSEL_IRC      2'h0
// pll enable and connect level after any chip reset
`define CRS_PLL_OFF         1'b0
// oscillator activity: toggles seen since restart before it counts as running
`define CRS_OSC_TOGGLES     4'h8

`endif

// >>> hdl/crs_pkg.sv
package crs_pkg;
  typedef enum logic [2:0] {
    CRS_ST_HOLD  = 3'b000,
    CRS_ST_OSC   = 3'b001,
    CRS_ST_COUNT = 3'b010,
    CRS_ST_FLASH = 3'b011,
    CRS_ST_RUN   = 3'b100
  } crs_state_t;
endpackage

// >>> hdl/crs_osc_monitor.sv
`timescale 1ns/1ps
`include "crs_consts.svh"

module crs_osc_monitor
  import crs_pkg::*;
#(
  parameter logic [3:0] TOGGLES = `CRS_OSC_TOGGLES
) (
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic restart,
  input  wire logic oscSample,
  output logic      oscStable
);
  logic [3:0] toggleCnt_reg;
  logic [3:0] toggleCnt_next;
  logic       lastSample_reg;
  logic       lastSample_next;
  logic       stable_reg;
  logic       stable_next;

  // a stuck oscillator stops toggling; any level change counts as activity
  always_comb begin
    toggleCnt_next  = toggleCnt_reg;
    lastSample_next = oscSample;
    stable_next     = stable_reg;
    if (restart) begin
      toggleCnt_next = 4'h0;
      stable_next    = 1'b0;
    end else if (oscSample != lastSample_reg && !stable_reg) begin
      toggleCnt_next = toggleCnt_reg + 4'h1;
      if (toggleCnt_next >= TOGGLES) begin
        stable_next = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      toggleCnt_reg  <= 4'h0;
      lastSample_reg <= 1'b0;
      stable_reg     <= 1'b0;
    end else begin
      toggleCnt_reg  <= toggleCnt_next;
      lastSample_reg <= lastSample_next;
      stable_reg     <= stable_next;
    end
  end

  assign oscStable = stable_reg;
endmodule // crs_osc_monitor

// >>> verification/crs_partner_model.sv
`timescale 1ns/1ps

module crs_partner_model (
  input  wire logic ref_clk,
  input  wire logic oscOn,
  input  wire logic chipReset,
  input  wire logic flashInitStart,
  output logic      crystalOscSample,
  output logic      flashInitDone
);
  logic       oscLevel_reg = 1'b0;
  logic       flashDone_reg = 1'b0;
  logic [3:0] flashCnt_reg = 4'h0;

  always @(posedge ref_clk) begin
    if (oscOn) oscLevel_reg <= ~oscLevel_reg;
  end

  // flash init is slow, and lost on chip reset
  always @(posedge ref_clk) begin
    if (chipReset) begin
      flashDone_reg <= 1'b0;
      flashCnt_reg <= 4'h0;
    end else if (flashInitStart) begin
      // a new start withdraws any earlier done
      flashDone_reg <= 1'b0;
      flashCnt_reg <= 4'h5;
    end else if (flashCnt_reg != 4'h0) begin
      flashCnt_reg <= flashCnt_reg - 4'h1;
      flashDone_reg <= (flashCnt_reg == 4'h1);
    end
  end

  assign crystalOscSample = oscLevel_reg;
  assign flashInitDone    = flashDone_reg;
endmodule // crs_partner_model

// >>> verification/chip_reset_sequencer_test.sv
`timescale 1ns/1ps

module chip_reset_sequencer_test;
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [4:0]  src = 5'h01;
  logic        oscOn = 1'b0;
  logic        chipReset, internalResetN, regResetReq, flashInitStart, crystalStable;
  logic        oscSample, flashDone, pllEnable, pllConnect;
  logic [31:0] fetchAddr;
  logic [1:0]  clockSelect;
  int          nErrors = 0;
  int          nCompared = 0;
  int          cycles = 0;
  int          n;

  always #2.5 ref_clk = ~ref_clk;

  chip_reset_sequencer #(.WAKE_COUNT(8)) dut (
    .ref_clk(ref_clk), .resetn(resetn), .extResetPinN(~src[0]),
    .watchdogTimerReset(src[1]), .powerOnReset(src[2]),
    .brownoutDetectorReset(src[3]), .supplyUsable(~src[4]),
    .crystalOscSample(oscSample), .flashInitDone(flashDone), .chipReset(chipReset),
    .internalResetN(internalResetN), .regResetReq(regResetReq),
    .flashInitStart(flashInitStart), .crystalStable(crystalStable),
    .fetchAddr(fetchAddr), .clockSelect(clockSelect), .pllEnable(pllEnable),
    .pllConnect(pllConnect));

  crs_partner_model partner (
    .ref_clk(ref_clk), .oscOn(oscOn), .chipReset(chipReset),
    .flashInitStart(flashInitStart), .crystalOscSample(oscSample),
    .flashInitDone(flashDone));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      nErrors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("errors %0d compared %0d", nErrors, nCompared);
    if (nErrors == 0 && nCompared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic drive(input logic [4:0] s, input logic osc);
    @(posedge ref_clk);
    src <= s;
    oscOn <= osc;
  endtask

  // waits for release, counting cycles and start pulses, then checks the run state
  task automatic wait_run;
    int starts;
    starts = 0;
    n = 0;
    while (internalResetN !== 1'b1 && n < 300) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (flashInitStart === 1'b1) starts++;
    end
    check("wake time", 32'(n >= 16 && n < 300), 32'h0000_0001);
    check("flash start", 32'(starts), 32'h0000_0001);
    // register reset gone with internal reset
    check("regReset", 32'(regResetReq), 32'h0000_0000);
    check("fetch", fetchAddr, 32'h0000_0000);
    check("clksel", 32'(clockSelect), 32'h0000_0000);
    check("pll", 32'({pllEnable, pllConnect}), 32'h0000_0000);
    check("stable", 32'(crystalStable), 32'h0000_0001);
  endtask

  task automatic t_sources;
    for (int i = 0; i < 5; i++) begin
      drive(5'(1 << i), 1'b1);
      repeat (2) @(posedge ref_clk);
      #1;
      check("chipReset", 32'(chipReset), 32'(i < 4));
      // internal reset held while a source or supply loss stands
      check("intReset", 32'(internalResetN), 32'h0000_0000);
      drive(5'h00, 1'b1);
      wait_run();
    end
  endtask

  task automatic t_osc_dead;
    drive(5'h02, 1'b0);
    drive(5'h00, 1'b0);
    repeat (60) @(posedge ref_clk);
    #1;
    check("oscDead", 32'(internalResetN), 32'h0000_0000);
    drive(5'h00, 1'b1);
    wait_run();
  endtask

  task automatic t_restart;
    drive(5'h08, 1'b1);
    drive(5'h00, 1'b1);
    // twelve cycles after release the wake count is part way through
    repeat (12) @(posedge ref_clk);
    drive(5'h08, 1'b1);
    drive(5'h00, 1'b1);
    wait_run();
    // a source mid-count restarts the full count
    check("restart", 32'(n >= 16), 32'h0000_0001);
  endtask

  // mid-run hard reset puts chip reset, register reset request, flash start and crystal stable back to their reset levels
  task automatic t_hard_reset;
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    check("hardChip", 32'(chipReset), 32'h0000_0001);
    check("hardReq", 32'(regResetReq), 32'h0000_0001);
    check("hardStart", 32'(flashInitStart), 32'h0000_0000);
    check("hardStable", 32'(crystalStable), 32'h0000_0000);
    @(posedge ref_clk);
    resetn <= 1'b1;
    wait_run();
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    // the whole run needs a few hundred cycles
    if (cycles == 4000) begin
      nErrors++;
      final_report();
    end
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    #1;
    check("rstChip", 32'(chipReset), 32'h0000_0001);
    check("rstReq", 32'(regResetReq), 32'h0000_0001);
    @(posedge ref_clk);
    resetn <= 1'b1;
    drive(5'h00, 1'b1);
    wait_run();
    t_sources();
    t_osc_dead();
    t_restart();
    t_hard_reset();
    final_report();
  end
endmodule // chip_reset_sequencer_test
